// >>> verilog/ccpu_top.sv
// Notes on behaviour
// - Period timer clears on the increment after it equals the period limit.
// - Rollover sets output high unless the duty value being copied into the buffer is zero.
// - Rollover copies duty value into a 10-bit buffer used for compare.
// - Duty register writable anytime; PWM uses new value only after next rollover, compare uses it at once.
// - Period is (limit+1) * 4 system clocks * prescale factor.
// - Time base is timer count plus two low bits from clock phase or prescaler.
// - Time base equal to buffered duty drives output low for rest of period.
// - Alignment bit picks left or right placement of duty in PWM mode only.
// - Postscaler has no effect on PWM period.
// - Sleep freezes timer and unit state, output held; resumes afterwards.
// - Reset returns pin to input and registers to reset values.
// - Duty beyond period never matches, output left unchanged.
// - Control bit 7 enables the unit.
// - Control bit 5 is read-only and shows the output level.
// - Mode 11xx is PWM, 0000 off, others compare/capture setting event flag.
// - Compare 1000 sets, 1001 clears, 1010 pulses, 0010 toggles output.
// - Compare 0001 and 1011 also clear the capture timer on match.
// - Capture codes pick any, falling, rising, 4th or 16th rising edge.
// - Right align: high[1:0]=duty[9:8]; left: high=duty[9:2], low[7:6]=duty[1:0].
// - Capture stores 16-bit timer into duty register, sets event flag, overwrites.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module ccpu_top
    import ccpu_pkg::*;
(
    input  wire logic        MCLK_IN,
    input  wire logic        SRST_IN,
    input  wire logic [13:0] PADDR_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        SLEEP_IN,
    input  wire logic        UNIT_PIN_IN,
    output logic             UNIT_PIN_OUT,
    output logic             UNIT_PIN_OE_N_OUT
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    ccpu_apb_req_t req;
    ccpu_ctl_t     ctl;
    logic [15:0]   duty_compare_value;
    logic [7:0]    period_limit;
    logic [2:0]    period_timer_control;
    logic          pin_direction_bit;
    logic          period_timer_flag;
    logic          unit_event_flag;
    logic [15:0]   capture_timer;
    logic [7:0]    period_timer_count;
    logic [1:0]    sys_phase;
    logic [5:0]    prescale_count;
    logic [9:0]    duty_buffer;
    logic          unit_out;
    logic          pulse_active;
    logic [3:0]    edge_count;
    logic          pin_sync1;
    logic          pin_sync2;
    logic          pin_prev;
    logic          matched;

    assign req = '{paddr: PADDR_IN, psel: PSEL_IN, penable: PENABLE_IN, pwrite: PWRITE_IN, pwdata: PWDATA_IN};

    logic wr_en;
    logic rd_en;
    logic hit;
    logic [31:0] next_rdata;
    assign wr_en = req.psel && req.penable && req.pwrite;
    assign rd_en = req.psel && !req.penable && !req.pwrite;

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    logic       pwm_mode;
    logic       run;
    logic [5:0] prescale_max;
    logic       tick;
    logic       step;
    logic       rollover;
    logic [1:0] low_bits;
    logic [9:0] time_base;
    logic [9:0] duty_aligned;
    logic       cap_mode;
    logic       cmp_mode;
    logic       cmp_match;

    assign pwm_mode = ctl.enable && (ctl.mode[3:2] == 2'b11);
    assign cap_mode = ctl.enable && (ctl.mode >= MODE_CAP_ANY) && (ctl.mode <= MODE_CAP_RISE16);
    assign cmp_mode = ctl.enable && !pwm_mode && !cap_mode && (ctl.mode != MODE_OFF);
    assign run = period_timer_control[TCTL_ON_BIT] && !SLEEP_IN;

    // Low time base bits are the clock phase at 1:1, else the two prescaler bits that step four times per prescale period
    always_comb begin
        unique case (period_timer_control[1:0])
            2'b00: begin
                prescale_max = 6'h00;
                low_bits = sys_phase;
            end
            2'b01: begin
                prescale_max = 6'h03;
                low_bits = prescale_count[1:0];
            end
            2'b10: begin
                prescale_max = 6'h0f;
                low_bits = prescale_count[3:2];
            end
            default: begin
                prescale_max = 6'h3f;
                low_bits = prescale_count[5:4];
            end
        endcase
    end

    assign tick = run && (sys_phase == 2'(SYS_PER_TICK - 1)) && (prescale_count == prescale_max);
    assign rollover = tick && (period_timer_count == period_limit);
    // Edge at which the time base moves on by one
    assign step = run && ((prescale_max == 6'h00) || ((sys_phase == 2'(SYS_PER_TICK - 1)) &&
                  ((prescale_count & (prescale_max >> 2)) == (prescale_max >> 2))));
    assign time_base = {period_timer_count, low_bits};
    // Left alignment takes duty from bits 15:6, right from bits 9:0
    assign duty_aligned = ctl.duty_align ? duty_compare_value[15:6] : duty_compare_value[9:0];
    assign cmp_match = cmp_mode && (capture_timer == duty_compare_value);

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            sys_phase <= 2'h0;
            prescale_count <= 6'h00;
            period_timer_count <= 8'h00;
        end else if (run) begin
            sys_phase <= sys_phase + 2'h1;
            if (sys_phase == 2'(SYS_PER_TICK - 1)) begin
                prescale_count <= (prescale_count == prescale_max) ? 6'h00 : prescale_count + 6'h01;
            end
            if (tick) begin
                period_timer_count <= rollover ? 8'h00 : period_timer_count + 8'h01;
            end
        end
    end

    // Capture/compare timer: steps on clock phase 3, so at quarter rate while the period timer runs; cleared by modes 0001 and 1011
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            capture_timer <= 16'h0000;
        end else if (!SLEEP_IN && sys_phase == 2'(SYS_PER_TICK - 1)) begin
            if (cmp_match && (ctl.mode == MODE_TOG_CLR || ctl.mode == MODE_PULSE_CLR)) begin
                capture_timer <= 16'h0000;
            end else begin
                capture_timer <= capture_timer + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Input synchroniser and capture edge detect
    // ------------------------------------------------------------
    logic rise;
    logic fall;
    logic cap_event;
    assign rise = pin_sync2 && !pin_prev;
    assign fall = !pin_sync2 && pin_prev;

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_sync1 <= UNIT_PIN_IN;
            pin_sync2 <= pin_sync1;
            pin_prev <= pin_sync2;
        end
    end

    always_comb begin
        cap_event = 1'b0;
        if (cap_mode && !SLEEP_IN) begin
            unique case (ctl.mode)
                MODE_CAP_ANY:    cap_event = rise || fall;
                MODE_CAP_FALL:   cap_event = fall;
                MODE_CAP_RISE:   cap_event = rise;
                MODE_CAP_RISE4:  cap_event = rise && (edge_count[1:0] == 2'h3);
                MODE_CAP_RISE16: cap_event = rise && (edge_count == 4'hf);
                default:         cap_event = 1'b0;
            endcase
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN || !cap_mode) begin
            edge_count <= 4'h0;
        end else if (rise && !SLEEP_IN) begin
            edge_count <= edge_count + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Output logic
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            duty_buffer <= 10'h000;
        end else if (rollover) begin
            duty_buffer <= duty_aligned;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            unit_out <= 1'b0;
            pulse_active <= 1'b0;
            matched <= 1'b0;
        end else if (!ctl.enable || ctl.mode == MODE_OFF) begin
            unit_out <= 1'b0;
            pulse_active <= 1'b0;
            matched <= 1'b0;
        end else if (SLEEP_IN) begin
            unit_out <= unit_out;
        end else if (pwm_mode) begin
            if (rollover) begin
                unit_out <= (duty_aligned != 10'h000);
            // Cleared on the step into the duty value, so the high time is duty steps long
            end else if (step && (time_base + 10'h001 == duty_buffer)) begin
                unit_out <= 1'b0;
            end
        end else if (cmp_mode) begin
            pulse_active <= 1'b0;
            if (pulse_active) begin
                unit_out <= 1'b0;
            end
            matched <= cmp_match;
            if (cmp_match && !matched) begin
                unique case (ctl.mode)
                    MODE_SET:   unit_out <= 1'b1;
                    MODE_CLEAR: unit_out <= 1'b0;
                    MODE_PULSE, MODE_PULSE_CLR: begin
                        unit_out <= 1'b1;
                        pulse_active <= 1'b1;
                    end
                    default:    unit_out <= !unit_out;
                endcase
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            UNIT_PIN_OUT <= 1'b0;
            UNIT_PIN_OE_N_OUT <= 1'b1;
        end else begin
            UNIT_PIN_OUT <= unit_out;
            UNIT_PIN_OE_N_OUT <= pin_direction_bit;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            ctl <= '{enable: CTL_RESET[CTL_EN_BIT], duty_align: CTL_RESET[CTL_ALIGN_BIT], mode: CTL_RESET[3:0]};
            period_limit <= LIMIT_RESET;
            period_timer_control <= TCTL_RESET;
            pin_direction_bit <= 1'b1;
        end else if (wr_en) begin
            if (req.paddr == ADDR_CONTROL) begin
                ctl.enable <= req.pwdata[CTL_EN_BIT];
                ctl.duty_align <= req.pwdata[CTL_ALIGN_BIT];
                ctl.mode <= req.pwdata[3:0];
            end
            if (req.paddr == ADDR_LIMIT) begin
                period_limit <= req.pwdata[7:0];
            end
            if (req.paddr == ADDR_TIMER_CTL) begin
                period_timer_control <= req.pwdata[2:0];
                pin_direction_bit <= req.pwdata[8];
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            duty_compare_value <= 16'h0000;
        end else if (cap_event) begin
            duty_compare_value <= capture_timer;
        end else if (wr_en && req.paddr == ADDR_DUTY) begin
            duty_compare_value <= req.pwdata[15:0];
        end
    end

    // Flags: hardware set wins over write-one-to-clear
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            period_timer_flag <= 1'b0;
            unit_event_flag <= 1'b0;
        end else begin
            if (rollover) begin
                period_timer_flag <= 1'b1;
            end else if (wr_en && req.paddr == ADDR_STATUS && req.pwdata[ST_TIMER_FLAG]) begin
                period_timer_flag <= 1'b0;
            end
            if (cap_event || (cmp_match && !matched) || (pwm_mode && rollover)) begin
                unit_event_flag <= 1'b1;
            end else if (wr_en && req.paddr == ADDR_STATUS && req.pwdata[ST_EVENT_FLAG]) begin
                unit_event_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // APB read path: no wait state, data ready in first access cycle
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        hit = 1'b1;
        unique case (req.paddr)
            ADDR_CONTROL:   next_rdata[7:0] = {ctl.enable, 1'b0, unit_out, ctl.duty_align, ctl.mode};
            ADDR_DUTY:      next_rdata[15:0] = duty_compare_value;
            ADDR_LIMIT:     next_rdata[7:0] = period_limit;
            ADDR_TIMER_CTL: next_rdata[8:0] = {pin_direction_bit, 5'h00, period_timer_control};
            ADDR_STATUS:    next_rdata[1:0] = {unit_event_flag, period_timer_flag};
            ADDR_CAP_TIMER: next_rdata[23:0] = {period_timer_count, capture_timer};
            default:        hit = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= req.psel && !req.penable;
            PSLVERR_OUT <= req.psel && !req.penable && !hit;
            if (rd_en) begin
                PRDATA_OUT <= next_rdata;
            end
        end
    end
endmodule : ccpu_top
`default_nettype wire

// >>> verilog/ccpu_pkg.sv
package ccpu_pkg;
    // Register byte addresses (printed offsets are not all multiples of four, so index * 4)
    localparam logic [11:0] CONTROL_INDEX    = 12'h30e;
    localparam logic [11:0] DUTY_INDEX       = 12'h30c;
    localparam logic [11:0] LIMIT_INDEX      = 12'h300;
    localparam logic [11:0] TIMER_CTL_INDEX  = 12'h301;
    localparam logic [11:0] STATUS_INDEX     = 12'h302;
    localparam logic [11:0] CAP_TIMER_INDEX  = 12'h303;
    localparam logic [13:0] ADDR_CONTROL     = {CONTROL_INDEX, 2'b00};
    localparam logic [13:0] ADDR_DUTY        = {DUTY_INDEX, 2'b00};
    localparam logic [13:0] ADDR_LIMIT       = {LIMIT_INDEX, 2'b00};
    localparam logic [13:0] ADDR_TIMER_CTL   = {TIMER_CTL_INDEX, 2'b00};
    localparam logic [13:0] ADDR_STATUS      = {STATUS_INDEX, 2'b00};
    localparam logic [13:0] ADDR_CAP_TIMER   = {CAP_TIMER_INDEX, 2'b00};

    // Control register fields
    localparam int          CTL_EN_BIT       = 7;
    localparam int          CTL_OUT_BIT      = 5;
    localparam int          CTL_ALIGN_BIT    = 4;
    localparam logic [7:0]  CTL_RESET        = 8'h00;
    localparam logic [7:0]  CTL_WRITE_MASK   = 8'h9f;

    // Period timer control fields
    localparam int          TCTL_ON_BIT      = 2;
    localparam logic [2:0]  TCTL_RESET       = 3'h0;
    localparam logic [7:0]  LIMIT_RESET      = 8'hff;

    // Status register bits (write one to clear)
    localparam int          ST_TIMER_FLAG    = 0;
    localparam int          ST_EVENT_FLAG    = 1;

    // Timing: period timer advances once per four system clocks at 1:1 prescale
    localparam int          SYS_PER_TICK     = 4;

    // Mode codes
    localparam logic [3:0]  MODE_OFF         = 4'h0;
    localparam logic [3:0]  MODE_TOG_CLR     = 4'h1;
    localparam logic [3:0]  MODE_TOGGLE      = 4'h2;
    localparam logic [3:0]  MODE_CAP_ANY     = 4'h3;
    localparam logic [3:0]  MODE_CAP_FALL    = 4'h4;
    localparam logic [3:0]  MODE_CAP_RISE    = 4'h5;
    localparam logic [3:0]  MODE_CAP_RISE4   = 4'h6;
    localparam logic [3:0]  MODE_CAP_RISE16  = 4'h7;
    localparam logic [3:0]  MODE_SET         = 4'h8;
    localparam logic [3:0]  MODE_CLEAR       = 4'h9;
    localparam logic [3:0]  MODE_PULSE       = 4'ha;
    localparam logic [3:0]  MODE_PULSE_CLR   = 4'hb;

    typedef struct packed {
        logic       enable;
        logic       duty_align;
        logic [3:0] mode;
    } ccpu_ctl_t;

    typedef struct packed {
        logic [13:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } ccpu_apb_req_t;
endpackage : ccpu_pkg

// >>> tb/ccpu_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ccpu_properties
    import ccpu_pkg::*;
(
    input wire logic        MCLK_IN,
    input wire logic        SRST_IN,
    input wire logic [13:0] PADDR_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        SLEEP_IN,
    input wire logic        UNIT_PIN_IN,
    input wire logic        UNIT_PIN_OUT,
    input wire logic        UNIT_PIN_OE_N_OUT
);
    default clocking @(posedge MCLK_IN);
    endclocking
    default disable iff (SRST_IN);
    wire logic setup = PSEL_IN && !PENABLE_IN;
    wire logic known = PADDR_IN inside {ADDR_CONTROL, ADDR_DUTY, ADDR_LIMIT, ADDR_TIMER_CTL, ADDR_STATUS,
                                        ADDR_CAP_TIMER};
    // ----
    // Bus, reset, sleep and control output bit
    // ----
    a_ready_after_setup: assert property (setup |=> PREADY_OUT)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    a_error_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    a_unmapped_read: assert property (setup && !known && !PWRITE_IN |=> PSLVERR_OUT && PRDATA_OUT == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_no_error: assert property (setup && known |=> !PSLVERR_OUT)
        else $error("error on mapped address");
    a_reset_state: assert property (disable iff (1'b0) SRST_IN |=> !PREADY_OUT && !UNIT_PIN_OUT && UNIT_PIN_OE_N_OUT)
        else $error("outputs not at reset level");
    a_sleep_holds_pin: assert property (SLEEP_IN [*3] |-> $stable(UNIT_PIN_OUT))
        else $error("pin moved in sleep");
    a_out_bit_read: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == ADDR_CONTROL |->
        PRDATA_OUT[5] == UNIT_PIN_OUT && PRDATA_OUT[31:8] == 24'h0 && !PRDATA_OUT[6])
        else $error("control read wrong");
    c_unmapped: cover property (PSLVERR_OUT);
    c_sleep: cover property (SLEEP_IN [*3]);
    c_pin_rise: cover property ($rose(UNIT_PIN_OUT) && !UNIT_PIN_OE_N_OUT);
endmodule // ccpu_properties
bind ccpu_top ccpu_properties ccpu_properties_inst (
    .MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .PADDR_IN(PADDR_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .SLEEP_IN(SLEEP_IN), .UNIT_PIN_IN(UNIT_PIN_IN), .UNIT_PIN_OUT(UNIT_PIN_OUT),
    .UNIT_PIN_OE_N_OUT(UNIT_PIN_OE_N_OUT));
`default_nettype wire

// >>> tb/ccpu_load_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Load on the pin: drives it while released, times the waveform
// ----
module ccpu_load_model (
    input  wire logic clk_in,
    input  wire logic pin_in,
    input  wire logic level_in,
    output logic      ext_out,
    output var int    rises_out,
    output var int    period_out,
    output var int    high_out
);
    logic last     = 1'b0;
    int   cnt      = 0;
    int   hcnt     = 0;
    int   rise_cnt = 0;
    assign ext_out   = level_in;
    assign rises_out = rise_cnt;
    always @(posedge clk_in) begin
        last <= pin_in;
        cnt  <= cnt + 1;
        hcnt <= hcnt + (pin_in ? 1 : 0);
        if (pin_in && !last) begin // Each rise closes one whole period
            rise_cnt   <= rise_cnt + 1;
            period_out <= cnt;
            high_out   <= hcnt;
            cnt        <= 1;
            hcnt       <= 1;
        end
    end
endmodule // ccpu_load_model
`default_nettype wire

// >>> tb/capture_compare_pwm_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
module capture_compare_pwm_unit_tb
    import ccpu_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sleep = 1'b0;
    logic ext_req = 1'b0;
    ccpu_apb_req_t req = '0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, pin_out, oe_n, ext_lvl, pin;
    int err_total = 0;
    int comparisons = 0;
    int rises, period, high, lim, duty, pc, t0;
    int cycles = 0;
    logic [31:0] rnd = 32'h8f4d09eb;
    logic [31:0] r, x;
    logic e;
    logic [13:0] ra [4] = '{ADDR_CONTROL, ADDR_LIMIT, ADDR_TIMER_CTL, ADDR_STATUS};
    logic [31:0] rx [4] = '{{24'h0, CTL_RESET}, {24'h0, LIMIT_RESET}, {29'h20, TCTL_RESET}, 32'h0};
    logic [3:0] cm [5] = '{MODE_CAP_ANY, MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
    int cn [5] = '{1, 1, 1, 4, 16};
    logic [3:0] km [6] = '{MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_TOG_CLR, MODE_PULSE, MODE_PULSE_CLR};
    logic kx [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    always #5 clk = ~clk;
    assign pin = oe_n ? ext_lvl : pin_out;
    ccpu_top ccpu_top_inst (
        .MCLK_IN(clk), .SRST_IN(rst), .PADDR_IN(req.paddr), .PSEL_IN(req.psel), .PENABLE_IN(req.penable),
        .PWRITE_IN(req.pwrite), .PWDATA_IN(req.pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .SLEEP_IN(sleep), .UNIT_PIN_IN(pin), .UNIT_PIN_OUT(pin_out),
        .UNIT_PIN_OE_N_OUT(oe_n));
    ccpu_load_model ccpu_load_model_inst (.clk_in(clk), .pin_in(pin), .level_in(ext_req), .ext_out(ext_lvl),
        .rises_out(rises), .period_out(period), .high_out(high));
    // ----
    // Tasks
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] xe, input logic [31:0] g);
        comparisons++;
        if (g !== xe) begin
            $display("[FAIL] %s expected %h seen %h", n, xe, g);
            err_total++;
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic xe);
        @(posedge clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        chk("pslverr", xe, e);
        req <= '0;
    endtask
    task automatic poll(input int b);
        int n = 0;
        do begin
            apb(1'b0, ADDR_STATUS, 32'h0, 1'b0);
            n++;
        end while (r[b] !== 1'b1 && n < 3000);
        chk("status flag", 32'h1, r[b]);
    endtask
    task automatic wait_rises(input int k);
        int n = 0;
        int s = rises;
        while (rises < s + k && n < 20000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic pulses(input int k);
        repeat (k) begin
            ext_req <= 1'b1;
            repeat (8) @(posedge clk);
            ext_req <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask
    task automatic end_of_test;
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            err_total++;
            end_of_test();
        end
    end
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk("pin direction", 32'h1, oe_n);
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0, 1'b0);
            chk("reset value", rx[i], r);
        end
        apb(1'b0, 14'h0004, 32'h0, 1'b1);
        chk("unmapped read", 32'h0, r);
        apb(1'b1, ADDR_CONTROL, 32'h70, 1'b0);
        apb(1'b0, ADDR_CONTROL, 32'h0, 1'b0);
        chk("control bits", 32'h10, r);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            lim = 3 + 16 * i + rnd[3:0];
            pc = 3 - i;
            duty = 1 + rnd[31:16] % (4 * lim + 2);
            apb(1'b1, ADDR_TIMER_CTL, 32'h100, 1'b0);
            apb(1'b1, ADDR_LIMIT, lim, 1'b0);
            apb(1'b1, ADDR_CONTROL, 32'h8c | {rnd[8], 4'h0} | pc, 1'b0);
            apb(1'b1, ADDR_DUTY, rnd[8] ? duty << 6 : duty, 1'b0);
            apb(1'b1, ADDR_STATUS, 32'h3, 1'b0);
            apb(1'b1, ADDR_TIMER_CTL, 32'h104 | pc, 1'b0);
            poll(ST_TIMER_FLAG);
            apb(1'b1, ADDR_TIMER_CTL, 32'h4 | pc, 1'b0);
            wait_rises(3);
            chk("pwm period", (lim + 1) * 4 * (1 << 2 * pc), period);
            chk("pwm high time", duty * (1 << 2 * pc), high);
        end
        apb(1'b1, ADDR_CONTROL, 32'h8c, 1'b0);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, ADDR_DUTY, i ? 32'h3ff : 32'h0, 1'b0);
            repeat (600) @(posedge clk);
            t0 = rises;
            repeat (600) @(posedge clk);
            chk("rises at edge duty", t0, rises);
            chk("level at edge duty", i, pin_out);
        end
        sleep <= 1'b1;
        apb(1'b0, ADDR_CAP_TIMER, 32'h0, 1'b0);
        x = r;
        repeat (20) @(posedge clk);
        apb(1'b0, ADDR_CAP_TIMER, 32'h0, 1'b0);
        chk("frozen timers", x, r);
        sleep <= 1'b0;
        apb(1'b1, ADDR_TIMER_CTL, 32'h104, 1'b0);
        foreach (cm[i]) begin
            apb(1'b1, ADDR_CONTROL, 32'h0, 1'b0);
            apb(1'b1, ADDR_CONTROL, 32'h80 | cm[i], 1'b0);
            apb(1'b1, ADDR_STATUS, 32'h3, 1'b0);
            pulses(cn[i] - 1);
            apb(1'b0, ADDR_STATUS, 32'h0, 1'b0);
            chk("early capture", 32'h0, r[ST_EVENT_FLAG]);
            pulses(1);
            apb(1'b0, ADDR_STATUS, 32'h0, 1'b0);
            chk("capture event", 32'h1, r[ST_EVENT_FLAG]);
            apb(1'b0, ADDR_DUTY, 32'h0, 1'b0);
            x = r;
            apb(1'b0, ADDR_CAP_TIMER, 32'h0, 1'b0);
            chk("capture stamp", 32'h1, (r[15:0] - x[15:0]) < 16'h0040);
        end
        apb(1'b1, ADDR_TIMER_CTL, 32'h4, 1'b0);
        foreach (km[i]) begin
            apb(1'b1, ADDR_CONTROL, 32'h0, 1'b0);
            apb(1'b0, ADDR_CAP_TIMER, 32'h0, 1'b0);
            chk("released level", 32'h0, pin_out);
            apb(1'b1, ADDR_DUTY, r[15:0] + 16'h0018, 1'b0);
            apb(1'b1, ADDR_STATUS, 32'h3, 1'b0);
            apb(1'b1, ADDR_CONTROL, 32'h80 | km[i], 1'b0);
            poll(ST_EVENT_FLAG);
            repeat (3) @(posedge clk);
            chk("compare level", kx[i], pin_out);
            apb(1'b0, ADDR_CAP_TIMER, 32'h0, 1'b0);
            if (km[i] == MODE_TOG_CLR || km[i] == MODE_PULSE_CLR) begin
                chk("cleared timer", 32'h1, r[15:0] < 16'h0040);
            end
        end
        end_of_test();
    end
endmodule // capture_compare_pwm_unit_tb
`default_nettype wire
